//--- inc/hcips_pkg.sv
// Package with the map, reset values and constants of the hub configuration power and swap block.
package hcips_pkg;

    // Number of configuration bytes held by this block.
    localparam int CFG_COUNT = 8;

    // Register indices; the bus byte address is four times the index.
    localparam logic [7:0] IDX_CUR_SELF = 8'h2E;
    localparam logic [7:0] IDX_CUR_BUS = 8'h2F;
    localparam logic [7:0] IDX_PWR_ON = 8'h30;
    localparam logic [7:0] IDX_BOOST_UP = 8'h31;
    localparam logic [7:0] IDX_RSVD_A = 8'h32;
    localparam logic [7:0] IDX_BOOST_DN = 8'h33;
    localparam logic [7:0] IDX_RSVD_B = 8'h34;
    localparam logic [7:0] IDX_SWAP = 8'h35;
    localparam logic [7:0] IDX_STATUS = 8'h3F;

    // Slot numbers inside the byte array, counted from the first index.
    localparam int SLOT_CUR_SELF = 0;
    localparam int SLOT_CUR_BUS = 1;
    localparam int SLOT_PWR_ON = 2;
    localparam int SLOT_BOOST_UP = 3;
    localparam int SLOT_RSVD_A = 4;
    localparam int SLOT_BOOST_DN = 5;
    localparam int SLOT_RSVD_B = 6;
    localparam int SLOT_SWAP = 7;

    // Reset and default values.
    localparam logic [7:0] RST_CUR_SELF = 8'h01;
    localparam logic [7:0] RST_CUR_BUS = 8'h00;
    localparam logic [7:0] RST_PWR_ON = 8'h32;
    localparam logic [7:0] RST_BOOST_UP = 8'h00;
    localparam logic [7:0] RST_RSVD = 8'h00;
    localparam logic [7:0] RST_BOOST_DN = 8'h00;
    localparam logic [7:0] RST_SWAP = 8'h00;

    // Swap byte layout: only bits 0, 2 and 3 carry a port.
    localparam logic [7:0] SWAP_VALID_MASK = 8'h0D;
    localparam int PORT_COUNT = 3;
    localparam int SWAP_BIT_UP = 0;
    localparam int SWAP_BIT_DN2 = 2;
    localparam int SWAP_BIT_DN3 = 3;

    // Units of the current and power-on fields.
    localparam int CURRENT_UNIT_MA = 2;
    localparam int SELF_CURRENT_LIMIT_MA = 100;
    localparam logic [7:0] SELF_CURRENT_LIMIT_CODE = 8'(SELF_CURRENT_LIMIT_MA / CURRENT_UNIT_MA);
    localparam int POWER_ON_UNIT_MS = 2;
    localparam int POWER_ON_WAIT_W = 9;

    // Status register bit positions.
    localparam int STAT_IMAGE_LOADED = 0;
    localparam int STAT_DEFAULTS_USED = 1;
    localparam int STAT_SELF_OVER_LIMIT = 2;

    // Bus constants.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 9;

    // Default value of one slot of the byte array.
    function automatic logic [7:0] hcips_default(input int slot);
        case (slot)
            SLOT_CUR_SELF: hcips_default = RST_CUR_SELF;
            SLOT_CUR_BUS: hcips_default = RST_CUR_BUS;
            SLOT_PWR_ON: hcips_default = RST_PWR_ON;
            SLOT_BOOST_UP: hcips_default = RST_BOOST_UP;
            SLOT_BOOST_DN: hcips_default = RST_BOOST_DN;
            SLOT_SWAP: hcips_default = RST_SWAP;
            default: hcips_default = RST_RSVD;
        endcase
    endfunction : hcips_default

    // Bits of a slot that may hold anything other than zero.
    function automatic logic [7:0] hcips_keep_mask(input int slot);
        case (slot)
            SLOT_RSVD_A: hcips_keep_mask = 8'h00;
            SLOT_RSVD_B: hcips_keep_mask = 8'h00;
            SLOT_SWAP: hcips_keep_mask = SWAP_VALID_MASK;
            default: hcips_keep_mask = 8'hFF;
        endcase
    endfunction : hcips_keep_mask

endpackage : hcips_pkg

//--- rtl/hcips_pin_swap.sv
// One USB port's differential pin swap with synchronised pin inputs and registered outputs.
module hcips_pin_swap
    import hcips_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic swap,
    input wire logic tx_dplus,
    input wire logic tx_dminus,
    input wire logic tx_oe,
    input wire logic pin_pos_in,
    input wire logic pin_neg_in,
    output logic rx_dplus,
    output logic rx_dminus,
    output logic pin_pos_out,
    output logic pin_neg_out,
    output logic pin_oe
);

    logic [1:0] pos_sync;
    logic [1:0] neg_sync;
    logic next_pin_pos_out;
    logic next_pin_neg_out;
    logic next_rx_dplus;
    logic next_rx_dminus;

    // With swap set the D+ function goes to the negative-labelled pin and back.
    assign next_pin_pos_out = swap ? tx_dminus : tx_dplus;
    assign next_pin_neg_out = swap ? tx_dplus : tx_dminus;
    assign next_rx_dplus = swap ? neg_sync[1] : pos_sync[1];
    assign next_rx_dminus = swap ? pos_sync[1] : neg_sync[1];

    // Pins come from outside the clock domain, so they pass two flip-flops first.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pos_sync <= 2'h0;
            neg_sync <= 2'h0;
            rx_dplus <= 1'b0;
            rx_dminus <= 1'b0;
            pin_pos_out <= 1'b0;
            pin_neg_out <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pos_sync <= {pos_sync[0], pin_pos_in};
            neg_sync <= {neg_sync[0], pin_neg_in};
            rx_dplus <= next_rx_dplus;
            rx_dminus <= next_rx_dminus;
            pin_pos_out <= next_pin_pos_out;
            pin_neg_out <= next_pin_neg_out;
            pin_oe <= tx_oe;
        end
    end

endmodule : hcips_pin_swap

//--- rtl/hcips_config.sv
// Hub configuration bytes for controller current, power-on time, boost and pin swap, with an AHB-Lite slave.
//
// Overview of operation
// - Self-powered controller current byte counts 2 mA units, hub only; default one.
// - Bus-powered controller current byte counts 2 mA units, hub only; default zero.
// - Power-on byte counts 2 ms intervals to power good; default 50; reported.
// - Swap bit set: D+ function on negative pin, D- on positive pin.
// - Swap bit clear: functions stay on their own pins; all swaps default clear.
// - Swap byte bit 0 swaps the upstream port.
// - Swap byte bit 3 swaps downstream port 3, bit 2 port 2.
// - Swap bits 1 and 7 to 4 are reserved, no effect, written zero.
// - Upstream drive boost byte loaded from its position; default zero.
// - Downstream ports 2 and 3 boost byte loaded from its position; default zero.
//
// The AHB-Lite slave port is this design's own decision.
module hcips_config
    import hcips_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Byte stream from the configuration image loader, same clock.
    input wire logic load_strobe,
    input wire logic [7:0] load_offset,
    input wire logic [7:0] load_data,
    input wire logic load_done,
    input wire logic load_image_valid,
    // Values handed to the hub core.
    output logic [7:0] controller_current_self_powered,
    output logic [7:0] controller_current_bus_powered,
    output logic [7:0] port_power_on_delay,
    output logic [POWER_ON_WAIT_W-1:0] power_on_wait_ms,
    output logic [7:0] upstream_drive_boost,
    output logic [7:0] downstream_drive_boost,
    output logic [PORT_COUNT-1:0] port_swapped,
    // Core side of the three ports: 0 upstream, 1 downstream 2, 2 downstream 3.
    input wire logic [PORT_COUNT-1:0] core_tx_dplus,
    input wire logic [PORT_COUNT-1:0] core_tx_dminus,
    input wire logic [PORT_COUNT-1:0] core_tx_oe,
    output logic [PORT_COUNT-1:0] core_rx_dplus,
    output logic [PORT_COUNT-1:0] core_rx_dminus,
    // Pin side of the three ports.
    input wire logic [PORT_COUNT-1:0] positive_labelled_pin_in,
    input wire logic [PORT_COUNT-1:0] negative_labelled_pin_in,
    output logic [PORT_COUNT-1:0] positive_labelled_pin_out,
    output logic [PORT_COUNT-1:0] negative_labelled_pin_out,
    output logic [PORT_COUNT-1:0] pin_oe
);

    // Map of port number to swap byte bit.
    localparam int SWAP_BIT_OF_PORT [PORT_COUNT] = '{SWAP_BIT_UP, SWAP_BIT_DN2, SWAP_BIT_DN3};

    // Returns whether a register index is the one mapped to the given array slot.
    function automatic logic slot_hit(input logic [7:0] idx, input int slot);
        slot_hit = (idx == 8'(IDX_CUR_SELF + slot[7:0]));
    endfunction : slot_hit

    logic [7:0] cfg [CFG_COUNT];
    logic [7:0] staged [CFG_COUNT];
    logic image_loaded;
    logic defaults_used;
    logic self_over_limit;
    logic wr_pending;
    logic [7:0] wr_index;

    wire addr_phase = hsel & hready & htrans[1];
    wire [7:0] addr_index = haddr[ADDR_MSB:ADDR_LSB];
    wire addr_write = addr_phase & hwrite & (hsize == HSIZE_WORD);
    wire bus_write = wr_pending;
    wire commit_image = load_done & load_image_valid;
    wire restore_defaults = load_done & ~load_image_valid;
    wire [7:0] wdata_byte = hwdata[7:0];

    // Status of the block itself, read at the status index.
    wire [7:0] status_byte = {5'h00, self_over_limit, defaults_used, image_loaded};

    // A current above the legal self-powered figure is flagged, not clipped, since the image owns it.
    wire next_self_over_limit = cfg[SLOT_CUR_SELF] > SELF_CURRENT_LIMIT_CODE;

    // Byte array: bus writes, image commit and default restore; reserved bits never stored.
    generate
        for (genvar s = 0; s < CFG_COUNT; s++) begin : g_slot
            wire load_hit = load_strobe & slot_hit(load_offset, s);
            wire bus_hit = bus_write & slot_hit(wr_index, s);
            wire [7:0] keep = hcips_keep_mask(s);
            wire [7:0] next_staged = load_hit ? (load_data & keep) : staged[s];

            // Staged bytes only become live once the whole image is declared valid.
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    staged[s] <= hcips_default(s);
                end else if (load_done) begin
                    staged[s] <= hcips_default(s);
                end else begin
                    staged[s] <= next_staged;
                end
            end

            // A software write in the same cycle as a commit wins, as it is the later intent.
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    cfg[s] <= hcips_default(s);
                end else if (bus_hit) begin
                    cfg[s] <= wdata_byte & keep;
                end else if (commit_image) begin
                    cfg[s] <= next_staged;
                end else if (restore_defaults) begin
                    cfg[s] <= hcips_default(s);
                end
            end
        end
    endgenerate

    // Load status flags; a new load outcome replaces the old one.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            image_loaded <= 1'b0;
            defaults_used <= 1'b1;
            self_over_limit <= 1'b0;
        end else begin
            if (load_done) begin
                image_loaded <= load_image_valid;
                defaults_used <= ~load_image_valid;
            end
            self_over_limit <= next_self_over_limit;
        end
    end

    // Values for the core; the wait in ms is the count times the interval length.
    wire [POWER_ON_WAIT_W-1:0] next_power_on_wait =
        POWER_ON_WAIT_W'(cfg[SLOT_PWR_ON] * POWER_ON_UNIT_MS);

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            power_on_wait_ms <= POWER_ON_WAIT_W'(RST_PWR_ON * POWER_ON_UNIT_MS);
        end else begin
            power_on_wait_ms <= next_power_on_wait;
        end
    end

    assign controller_current_self_powered = cfg[SLOT_CUR_SELF];
    assign controller_current_bus_powered = cfg[SLOT_CUR_BUS];
    assign port_power_on_delay = cfg[SLOT_PWR_ON];
    assign upstream_drive_boost = cfg[SLOT_BOOST_UP];
    assign downstream_drive_boost = cfg[SLOT_BOOST_DN];

    // One swap unit per port, each picking its own bit of the swap byte.
    generate
        for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
            assign port_swapped[p] = cfg[SLOT_SWAP][SWAP_BIT_OF_PORT[p]];

            hcips_pin_swap u_swap (
                .ref_clk(ref_clk),
                .rstn(rstn),
                .swap(port_swapped[p]),
                .tx_dplus(core_tx_dplus[p]),
                .tx_dminus(core_tx_dminus[p]),
                .tx_oe(core_tx_oe[p]),
                .pin_pos_in(positive_labelled_pin_in[p]),
                .pin_neg_in(negative_labelled_pin_in[p]),
                .rx_dplus(core_rx_dplus[p]),
                .rx_dminus(core_rx_dminus[p]),
                .pin_pos_out(positive_labelled_pin_out[p]),
                .pin_neg_out(negative_labelled_pin_out[p]),
                .pin_oe(pin_oe[p])
            );
        end
    endgenerate

    // Read selection at the address phase; unmapped indices read zero.
    logic [7:0] read_byte;
    always_comb begin
        read_byte = 8'h00;
        for (int s = 0; s < CFG_COUNT; s++) begin
            if (slot_hit(addr_index, s)) begin
                read_byte = cfg[s];
            end
        end
        if (addr_index == IDX_STATUS) begin
            read_byte = status_byte;
        end
    end

    // A read right behind a write to the same index sees the new data, masked as it will be stored.
    logic [7:0] fwd_byte;
    always_comb begin
        fwd_byte = read_byte;
        for (int s = 0; s < CFG_COUNT; s++) begin
            if (bus_write && slot_hit(wr_index, s) && slot_hit(addr_index, s)) begin
                fwd_byte = wdata_byte & hcips_keep_mask(s);
            end
        end
    end

    wire [31:0] next_hrdata = (addr_phase & ~hwrite) ? {24'h000000, fwd_byte} : 32'h00000000;

    // Zero-wait slave: the address phase is latched, data moves in the following cycle.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wr_pending <= 1'b0;
            wr_index <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pending <= addr_write;
            wr_index <= addr_index;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule : hcips_config

//--- tb/hcips_image_model.sv
// Behavioural model of the configuration image source that streams bytes into the block.
module hcips_image_model
    import hcips_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic go,
    input wire logic image_ok,
    input wire logic slow,
    output logic load_strobe,
    output logic [7:0] load_offset,
    output logic [7:0] load_data,
    output logic load_done,
    output logic load_image_valid,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] image [0:8];
    logic [3:0] pos;
    logic [1:0] gap;
    // Self current 0x32 is exactly 100 mA, the largest legal figure.
    // Reserved bytes and reserved swap bits are written as zero; the last byte lies outside the block.
    initial begin
        image = '{8'h32, 8'h7F, 8'h10, 8'hA5, 8'h00, 8'h5A, 8'h00, 8'h0C, 8'hEE};
        {load_strobe, load_offset, load_data, load_done, load_image_valid, busy, pos, gap} = '0;
    end
    // Idle lines toggle so that nothing can lean on a stale byte.
    always @(posedge ref_clk) begin
        load_strobe <= 1'b0;
        load_done <= 1'b0;
        load_offset <= ~load_offset;
        load_data <= ~load_data;
        load_image_valid <= ~load_image_valid;
        if (!rstn) begin
            busy <= 1'b0;
        end else if (go && !busy) begin
            busy <= 1'b1;
            pos <= 4'h0;
            gap <= 2'h0;
        end else if (busy && gap != 2'h0) begin
            gap <= gap - 2'h1;
        end else if (busy && pos < 4'h9) begin
            load_strobe <= 1'b1;
            load_offset <= IDX_CUR_SELF + 8'(pos);
            load_data <= image[pos];
            pos <= pos + 4'h1;
            gap <= slow ? 2'h2 : 2'h0;
        end else if (busy) begin
            load_done <= 1'b1;
            load_image_valid <= image_ok;
            busy <= 1'b0;
        end
    end
endmodule : hcips_image_model

//--- tb/hcips_config_monitor.sv
// Concurrent checks on the ports of the hub configuration power and swap block.
module hcips_config_monitor
    import hcips_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic load_done,
    input wire logic load_image_valid,
    input wire logic [7:0] controller_current_self_powered,
    input wire logic [7:0] port_power_on_delay,
    input wire logic [POWER_ON_WAIT_W-1:0] power_on_wait_ms,
    input wire logic [PORT_COUNT-1:0] port_swapped,
    input wire logic [PORT_COUNT-1:0] core_tx_dplus,
    input wire logic [PORT_COUNT-1:0] core_tx_dminus,
    input wire logic [PORT_COUNT-1:0] positive_labelled_pin_out,
    input wire logic [PORT_COUNT-1:0] negative_labelled_pin_out
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // A word request to one index in its address phase, and a write through its data phase.
    sequence s_req(w, idx);
        hsel && hready && htrans[1] && hwrite == w && hsize == HSIZE_WORD && haddr[9:2] == idx;
    endsequence
    sequence s_wr(idx);
        s_req(1'b1, idx) ##1 1'b1;
    endsequence
    // An invalid image brings the bytes and the swap routing back in the same cycle; the swap is checked one cycle later.
    sequence s_defaults;
        controller_current_self_powered == RST_CUR_SELF && port_power_on_delay == RST_PWR_ON ##1 port_swapped == 3'h0;
    endsequence
    a_swap_write: assert property (
        s_wr(IDX_SWAP) |=> port_swapped == $past({hwdata[3], hwdata[2], hwdata[0]}))
        else $error("swapped ports differ from written bits");
    a_self_write: assert property (
        s_wr(IDX_CUR_SELF) |=> controller_current_self_powered == $past(hwdata[7:0]))
        else $error("self current byte differs from written value");
    a_rsvd_read: assert property ((s_req(1'b0, IDX_RSVD_A) or s_req(1'b0, IDX_RSVD_B)) |=> hrdata == 32'h0)
        else $error("reserved byte read not zero");
    a_swap_read: assert property (s_req(1'b0, IDX_SWAP) |=> (hrdata & 32'hFFFFFFF2) == 32'h0)
        else $error("reserved swap bits read not zero");
    a_wait_double: assert property ($past(rstn) |-> power_on_wait_ms == {$past(port_power_on_delay), 1'b0})
        else $error("power on wait is not twice the delay byte");
    a_pin_pos: assert property (
        $past(rstn) |-> positive_labelled_pin_out ==
            $past((core_tx_dplus & ~port_swapped) | (core_tx_dminus & port_swapped)))
        else $error("positive pin drive wrong");
    a_pin_neg: assert property (
        $past(rstn) |-> negative_labelled_pin_out ==
            $past((core_tx_dminus & ~port_swapped) | (core_tx_dplus & port_swapped)))
        else $error("negative pin drive wrong");
    a_default_load: assert property (load_done && !load_image_valid |=> s_defaults)
        else $error("defaults not taken after invalid image");
endmodule : hcips_config_monitor
bind hcips_config hcips_config_monitor u_mon (.*);

//--- tb/hcips_config_tb_top.sv
// Self-checking bench for the hub configuration power and swap block.
`define CHK(g, w) begin \
    compares++; \
    if ((g) !== (w)) begin \
        mismatches++; \
        $display("unexpected at %0t: got %h want %h", $time, (g), (w)); \
    end \
end
module hub_config_image_power_swap_tb_top
    import hcips_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, image_ok = 1'b0, slow = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, core_tx_dplus = 3'h0, core_tx_dminus = 3'h0, core_tx_oe = 3'h0;
    logic [2:0] positive_labelled_pin_in = 3'h0, negative_labelled_pin_in = 3'h0;
    wire logic hready, hreadyout, hresp, load_strobe, load_done, load_image_valid, busy;
    wire logic [31:0] hrdata;
    wire logic [7:0] load_offset, load_data, controller_current_self_powered, controller_current_bus_powered;
    wire logic [7:0] port_power_on_delay, upstream_drive_boost, downstream_drive_boost;
    wire logic [8:0] power_on_wait_ms;
    wire logic [2:0] port_swapped, core_rx_dplus, core_rx_dminus, pin_oe;
    wire logic [2:0] positive_labelled_pin_out, negative_labelled_pin_out;
    int mismatches = 0, compares = 0;
    // The single slave's ready is the bus ready.
    assign hready = hreadyout;
    always #50 ref_clk = ~ref_clk;
    hcips_config u_dut (.*);
    hcips_image_model u_model (.*);
    task finish_test;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    // One single transfer; the address phase is held until ready is seen, then the data phase likewise.
    task xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [2:0] sz);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= sz;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
        // The slave never stretches a transfer and always answers OKAY.
        `CHK({hreadyout, hresp}, 2'h2)
    endtask : xfer
    task chk_rd(input logic [7:0] idx, input logic [7:0] w);
        xfer(1'b0, idx, 8'h00, HSIZE_WORD);
        `CHK(rd, {24'h0, w})
    endtask : chk_rd
    task t_reset;
        chk_rd(IDX_CUR_SELF, 8'h01);
        chk_rd(IDX_CUR_BUS, 8'h00);
        chk_rd(IDX_PWR_ON, 8'h32);
        chk_rd(IDX_BOOST_UP, 8'h00);
        chk_rd(IDX_BOOST_DN, 8'h00);
        chk_rd(IDX_SWAP, 8'h00);
        chk_rd(IDX_STATUS, 8'h02);
        `CHK(power_on_wait_ms, 9'h064)
    endtask : t_reset
    task t_regs;
        logic [7:0] idx;
        for (int i = 0; i < 8; i++) begin
            idx = IDX_CUR_SELF + 8'(i);
            xfer(1'b1, idx, 8'hA7, HSIZE_WORD);
            chk_rd(idx, (i == 4 || i == 6) ? 8'h00 : (i == 7) ? 8'h05 : 8'hA7);
        end
        `CHK(upstream_drive_boost, 8'hA7)
        `CHK(downstream_drive_boost, 8'hA7)
        `CHK(port_swapped, 3'h3)
        xfer(1'b0, IDX_STATUS, 8'h00, HSIZE_WORD);
        `CHK(rd[2], 1'b1)
        xfer(1'b1, IDX_CUR_SELF, 8'h32, HSIZE_WORD);
        xfer(1'b0, IDX_STATUS, 8'h00, HSIZE_WORD);
        `CHK(rd[2], 1'b0)
        `CHK(controller_current_self_powered, 8'h32)
        xfer(1'b1, IDX_CUR_BUS, 8'h11, 3'h0);
        chk_rd(IDX_CUR_BUS, 8'hA7);
        `CHK(controller_current_bus_powered, 8'hA7)
        xfer(1'b1, 8'h3A, 8'h55, HSIZE_WORD);
        chk_rd(8'h3A, 8'h00);
    endtask : t_regs
    // Every swap bit alone, then none; pin data differ on every port so a wrong route shows.
    task t_swap;
        logic [7:0] v;
        logic [2:0] s;
        core_tx_dplus <= 3'h5;
        core_tx_dminus <= 3'h2;
        core_tx_oe <= 3'h3;
        positive_labelled_pin_in <= 3'h6;
        negative_labelled_pin_in <= 3'h1;
        for (int i = 0; i < 9; i++) begin
            v = 8'h01 << i;
            s = {v[3], v[2], v[0]};
            xfer(1'b1, IDX_SWAP, v, HSIZE_WORD);
            repeat (4) @(posedge ref_clk);
            `CHK(port_swapped, s)
            `CHK(positive_labelled_pin_out, (3'h5 & ~s) | (3'h2 & s))
            `CHK(negative_labelled_pin_out, (3'h2 & ~s) | (3'h5 & s))
            `CHK(core_rx_dplus, (3'h6 & ~s) | (3'h1 & s))
            `CHK(core_rx_dminus, (3'h1 & ~s) | (3'h6 & s))
            `CHK(pin_oe, 3'h3)
        end
    endtask : t_swap
    task run_image(input logic ok, input logic sl);
        image_ok <= ok;
        slow <= sl;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (2) @(posedge ref_clk);
        for (int n = 0; n < 100 && busy === 1'b1; n++) @(posedge ref_clk);
        // A loader that never finishes is a failure, not something to wait out.
        if (busy !== 1'b0) begin
            $display("unexpected at %0t: image load never finished", $time);
            mismatches++;
            finish_test;
        end
        repeat (3) @(posedge ref_clk);
    endtask : run_image
    task t_load_valid;
        run_image(1'b1, 1'b1);
        `CHK(controller_current_self_powered, 8'h32)
        `CHK(controller_current_bus_powered, 8'h7F)
        `CHK(power_on_wait_ms, 9'h020)
        `CHK(upstream_drive_boost, 8'hA5)
        `CHK(downstream_drive_boost, 8'h5A)
        `CHK(port_swapped, 3'b110)
        chk_rd(IDX_STATUS, 8'h01);
    endtask : t_load_valid
    task t_load_default;
        run_image(1'b0, 1'b0);
        `CHK(controller_current_bus_powered, 8'h00)
        `CHK(port_power_on_delay, 8'h32)
        `CHK(downstream_drive_boost, 8'h00)
        `CHK(port_swapped, 3'h0)
        chk_rd(IDX_STATUS, 8'h02);
    endtask : t_load_default
    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset;
        t_regs;
        t_swap;
        t_load_valid;
        t_load_default;
        finish_test;
    end
    // The whole sequence needs well under a thousand cycles.
    initial begin
        #(5000 * 100);
        $display("unexpected at %0t: watchdog expired", $time);
        mismatches++;
        finish_test;
    end
endmodule : hub_config_image_power_swap_tb_top
